/* File: hw/acsf_flags.sv */
// Functional notes
// R1 - Only last-result read clears data-ready flag
// R2 - Channel or last-result read clears channel EOC
// R3 - Channel read clears only its own EOC
// R4 - Enabled completion stores results, sets data-ready
// R5 - Disabled completion stores nothing, no data-ready
// R6 - Completion with EOC set raises channel overrun
// R7 - Completion with data-ready set raises global overrun
// R8 - Status read clears global overrun, set wins
// R9 - Status read clears overrun once EOC cleared
// R10 - Disabling during conversion suppresses its EOC
// R11 - Sleep selected: sleep after started conversion ends
// R12 - Software sets sleep before issuing start
// R13 - Set beats coincident read clear
// R14 - Channel count is a parameter
//
// Decided for this implementation: the strobed register port and the address map.
`default_nettype none
module acsf_flags #(
  parameter int NUM_CH = acsf_pkg::NUM_CH // R14
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Register port
  input  wire acsf_pkg::acsf_bus_t bus,
  output logic [31:0]             rdata,
  // Conversion core
  input  wire acsf_pkg::acsf_conv_t conv,
  output logic                    start_conv,
  output logic [NUM_CH-1:0]       ch_enable,
  output logic                    sleep_active,
  // Interrupt
  output logic                    irq
);
  localparam int DW = acsf_pkg::DATA_W;
  localparam int CW = 3;
  typedef logic [acsf_pkg::ADDR_W-1:0] acsf_addr_t;

  logic [NUM_CH-1:0] en_q, en_d, eoc_q, eoc_d, ovr_q, ovr_d;
  logic [DW-1:0]     cdr_q [NUM_CH];
  logic [DW-1:0]     cdr_d [NUM_CH];
  logic [DW-1:0]     lcd_q, lcd_d;
  logic [CW-1:0]     lch_q, lch_d;
  logic              data_ready_flag_q, data_ready_flag_d, govr_q, govr_d;
  logic              sleep_sel_q, sleep_sel_d, slp_q, slp_d, busy_q, busy_d;
  logic              start_q, start_d;
  logic [acsf_pkg::IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d;
  logic              irq_q, irq_d;
  logic [31:0]       rdata_q, rdata_d;

  logic              done_ok, rd_last, rd_stat, rd_ch, wr_dis;
  logic [CW-1:0]     rd_idx;
  logic [NUM_CH-1:0] hit;

  assign rd_last = bus.rd && bus.addr == acsf_pkg::OFS_LAST;
  assign rd_stat = bus.rd && bus.addr == acsf_pkg::OFS_STATUS;
  assign rd_ch   = bus.rd && bus.addr >= acsf_pkg::OFS_CH_BASE
                   && bus.addr < acsf_pkg::OFS_CH_BASE + acsf_addr_t'(4 * NUM_CH);
  assign rd_idx  = CW'((bus.addr - acsf_pkg::OFS_CH_BASE) >> 2);
  assign wr_dis  = bus.wr && bus.addr == acsf_pkg::OFS_CH_DIS;
  // Enable sampled before this cycle's disable: a completion still counts
  assign done_ok = conv.done && en_q[conv.ch]; // R4 R5 R10

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic clr, set;
      // Clear keyed to this index only, never to a neighbour
      assign clr = (rd_ch && rd_idx == CW'(i)) || (rd_last && lch_q == CW'(i)); // R2 R3
      assign set = done_ok && conv.ch == CW'(i);
      assign hit[i] = set;
      always_comb begin
        eoc_d[i] = set ? 1'b1 : (clr ? 1'b0 : eoc_q[i]); // R13 R10
        ovr_d[i] = ovr_q[i];
        if (rd_stat && !eoc_q[i]) begin
          ovr_d[i] = 1'b0; // R9
        end
        if (set && eoc_q[i]) begin
          ovr_d[i] = 1'b1; // R6 R13
        end
        cdr_d[i] = set ? conv.data : cdr_q[i]; // R4
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          cdr_q[i] <= '0;
        end else begin
          cdr_q[i] <= cdr_d[i];
        end
      end

      AST_OVR_CLR: assert property (@(posedge clk_sys) disable iff (rst) // R9
        (rd_stat && !eoc_q[i]) |=> !ovr_q[i])
        else $error("channel overrun not cleared by status read");

      AST_OVR_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // R9
        (ovr_q[i] && !rd_stat) |=> ovr_q[i])
        else $error("channel overrun lost without status read");

      AST_EOC_NO_RISE: assert property (@(posedge clk_sys) disable iff (rst) // R10
        (!eoc_q[i] && !hit[i]) |=> !eoc_q[i])
        else $error("channel eoc rose without a stored completion");
    end
  endgenerate

  always_comb begin
    en_d = en_q;
    if (bus.wr && bus.addr == acsf_pkg::OFS_CH_EN) begin
      en_d = en_q | bus.wdata[NUM_CH-1:0];
    end
    if (wr_dis) begin
      en_d = en_q & ~bus.wdata[NUM_CH-1:0];
    end
    lcd_d = done_ok ? conv.data : lcd_q; // R4
    lch_d = done_ok ? conv.ch : lch_q;
    // Channel reads never touch data-ready
    data_ready_flag_d = done_ok ? 1'b1 : (rd_last ? 1'b0 : data_ready_flag_q); // R1 R4 R5 R13
    govr_d = (conv.done && data_ready_flag_q) ? 1'b1 : (rd_stat ? 1'b0 : govr_q); // R7 R8 R13
    sleep_sel_d = sleep_sel_q;
    if (bus.wr && bus.addr == acsf_pkg::OFS_MODE) begin
      sleep_sel_d = bus.wdata[acsf_pkg::MODE_SLEEP_BIT];
    end
    start_d = bus.wr && bus.addr == acsf_pkg::OFS_CTRL
              && bus.wdata[acsf_pkg::CTRL_START_BIT];
    busy_d = start_q ? 1'b1 : (conv.done ? 1'b0 : busy_q);
    // Sleep only takes effect at the end of a conversion, so idle writes wait
    slp_d = slp_q;
    if (start_q) begin
      slp_d = 1'b0;
    end
    if (busy_q && conv.done && sleep_sel_q) begin
      slp_d = 1'b1; // R11
    end
    if (!sleep_sel_q) begin
      slp_d = 1'b0;
    end
    ien_d = ien_q;
    if (bus.wr && bus.addr == acsf_pkg::OFS_IRQ_EN) begin
      ien_d = bus.wdata[acsf_pkg::IRQ_W-1:0];
    end
    ist_d = ist_q;
    if (bus.wr && bus.addr == acsf_pkg::OFS_IRQ_CLR) begin
      ist_d = ist_q & ~bus.wdata[acsf_pkg::IRQ_W-1:0];
    end
    if (done_ok) begin
      ist_d[acsf_pkg::IRQ_DATA_READY_FLAG] = 1'b1; // R13
    end
    if (conv.done && data_ready_flag_q) begin
      ist_d[acsf_pkg::IRQ_GOVR] = 1'b1;
    end
    if (done_ok && eoc_q[conv.ch]) begin
      ist_d[acsf_pkg::IRQ_OVR] = 1'b1;
    end
    irq_d = |(ist_d & ien_d);
    rdata_d = acsf_pkg::RESET_WORD;
    if (bus.rd) begin
      case (bus.addr)
        acsf_pkg::OFS_MODE:    rdata_d[acsf_pkg::MODE_SLEEP_BIT] = sleep_sel_q;
        acsf_pkg::OFS_CH_STAT: rdata_d[NUM_CH-1:0] = en_q;
        acsf_pkg::OFS_STATUS: begin
          rdata_d[NUM_CH-1:0] = eoc_q;
          rdata_d[acsf_pkg::ST_OVR_BASE +: NUM_CH] = ovr_q;
          rdata_d[acsf_pkg::ST_DATA_READY_FLAG_BIT] = data_ready_flag_q;
          rdata_d[acsf_pkg::ST_GOVR_BIT] = govr_q;
        end
        acsf_pkg::OFS_LAST: begin
          rdata_d[DW-1:0] = lcd_q;
          rdata_d[acsf_pkg::LAST_CH_POS +: CW] = lch_q;
        end
        acsf_pkg::OFS_IRQ_EN:  rdata_d[acsf_pkg::IRQ_W-1:0] = ien_q;
        acsf_pkg::OFS_IRQ_ST:  rdata_d[acsf_pkg::IRQ_W-1:0] = ist_q;
        default: begin
          if (rd_ch) begin
            rdata_d[DW-1:0] = cdr_q[rd_idx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_q        <= '0;
      eoc_q       <= '0;
      ovr_q       <= '0;
      lcd_q       <= '0;
      lch_q       <= '0;
      data_ready_flag_q      <= 1'b0;
      govr_q      <= 1'b0;
      sleep_sel_q <= 1'b0;
      slp_q       <= 1'b0;
      busy_q      <= 1'b0;
      start_q     <= 1'b0;
      ien_q       <= '0;
      ist_q       <= '0;
      irq_q       <= 1'b0;
      rdata_q     <= '0;
    end else begin
      en_q        <= en_d;
      eoc_q       <= eoc_d;
      ovr_q       <= ovr_d;
      lcd_q       <= lcd_d;
      lch_q       <= lch_d;
      data_ready_flag_q      <= data_ready_flag_d;
      govr_q      <= govr_d;
      sleep_sel_q <= sleep_sel_d;
      slp_q       <= slp_d;
      busy_q      <= busy_d;
      start_q     <= start_d;
      ien_q       <= ien_d;
      ist_q       <= ist_d;
      irq_q       <= irq_d;
      rdata_q     <= rdata_d;
    end
  end

  assign rdata        = rdata_q;
  assign start_conv   = start_q;
  assign ch_enable    = en_q;
  assign sleep_active = slp_q;
  assign irq          = irq_q;

  sequence s_ok_done;
    conv.done && en_q[conv.ch];
  endsequence

  sequence s_last_read;
    rd_last && !done_ok;
  endsequence

  sequence s_stat_over;
    rd_stat && conv.done && data_ready_flag_q;
  endsequence

  AST_DATA_READY_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst) // R4
    s_ok_done |=> data_ready_flag_q) else $error("data ready not set");
  AST_DATA_READY_FLAG_CHREAD: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (data_ready_flag_q && !rd_last) |=> data_ready_flag_q) else $error("data ready lost without last read");
  AST_DATA_READY_FLAG_DIS: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (!data_ready_flag_q && !done_ok) |=> !data_ready_flag_q) else $error("data ready set with no store");
  AST_EOC_CLR: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (rd_ch && !(done_ok && conv.ch == rd_idx)) |=> !eoc_q[$past(rd_idx)])
    else $error("channel eoc not cleared");
  AST_EOC_ONLY: assert property (@(posedge clk_sys) disable iff (rst) // R3
    (!rd_last) |=> ((eoc_q & ~$past(eoc_q)) == 0 || $past(done_ok))
    && ($countones($past(eoc_q) & ~eoc_q) <= 1)) else $error("extra eoc cleared");
  AST_OVR: assert property (@(posedge clk_sys) disable iff (rst) // R6
    (done_ok && eoc_q[conv.ch]) |=> ovr_q[$past(conv.ch)]) else $error("overrun missed");
  AST_GOVR: assert property (@(posedge clk_sys) disable iff (rst) // R7
    (conv.done && data_ready_flag_q) |=> govr_q) else $error("global overrun missed");
  AST_GOVR_CLR: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (rd_stat && !(conv.done && data_ready_flag_q)) |=> !govr_q) else $error("global overrun frozen");
  AST_EOC_DIS: assert property (@(posedge clk_sys) disable iff (rst) // R10
    (conv.done && !en_q[conv.ch] && !eoc_q[conv.ch]) |=> !eoc_q[$past(conv.ch)])
    else $error("eoc on disabled channel");
  AST_SLEEP: assert property (@(posedge clk_sys) disable iff (rst) // R11
    (busy_q && conv.done && sleep_sel_q && !start_q) |=> slp_q) else $error("no sleep");

  AST_HIT_ONEHOT: assert property (@(posedge clk_sys) disable iff (rst) // R3
    $onehot0(hit))
    else $error("completion decoded to several channels");

  AST_EOC_SET: assert property (@(posedge clk_sys) disable iff (rst) // R13
    s_ok_done |=> eoc_q[$past(conv.ch)])
    else $error("channel eoc lost to a coincident read");

  AST_CDR_STORE: assert property (@(posedge clk_sys) disable iff (rst) // R4
    s_ok_done |=> (cdr_q[$past(conv.ch)] == $past(conv.data)))
    else $error("channel result not stored");

  AST_LAST_STORE: assert property (@(posedge clk_sys) disable iff (rst) // R4
    s_ok_done |=> (lcd_q == $past(conv.data) && lch_q == $past(conv.ch)))
    else $error("last result not stored");

  AST_NO_STORE: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (conv.done && !en_q[conv.ch]) |=> (lcd_q == $past(lcd_q) && lch_q == $past(lch_q)))
    else $error("disabled channel overwrote last result");

  AST_DATA_READY_FLAG_CH_KEEP: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (data_ready_flag_q && rd_ch) |=> data_ready_flag_q)
    else $error("channel read cleared data ready");

  AST_LAST_CLR: assert property (@(posedge clk_sys) disable iff (rst) // R1
    s_last_read |=> !data_ready_flag_q)
    else $error("last result read left data ready set");

  AST_LAST_EOC: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (rd_last && !(done_ok && conv.ch == lch_q)) |=> !eoc_q[$past(lch_q)])
    else $error("last result read left channel eoc set");

  AST_GOVR_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (govr_q && !rd_stat) |=> govr_q)
    else $error("global overrun lost without status read");

  AST_GOVR_READ_SET: assert property (@(posedge clk_sys) disable iff (rst) // R8
    s_stat_over |=> govr_q)
    else $error("global overrun frozen under status read");

  AST_IST_SET: assert property (@(posedge clk_sys) disable iff (rst) // R13
    s_ok_done |=> ist_q[acsf_pkg::IRQ_DATA_READY_FLAG])
    else $error("data ready interrupt event lost");

  AST_SLEEP_DESEL: assert property (@(posedge clk_sys) disable iff (rst) // R11
    !sleep_sel_q |=> !slp_q)
    else $error("sleep without sleep selection");

  AST_EN_KEEP: assert property (@(posedge clk_sys) disable iff (rst) // R14
    !bus.wr |=> (en_q == $past(en_q)))
    else $error("channel enable changed without a write");
endmodule
`default_nettype wire

/* File: hw/acsf_pkg.sv */
`default_nettype none
package acsf_pkg;
  localparam int NUM_CH = 8;
  localparam int DATA_W = 10;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CH_EN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CH_DIS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CH_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_LAST = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_CH_BASE = 8'h30;
  // Field positions
  localparam int CTRL_START_BIT = 1;
  localparam int MODE_SLEEP_BIT = 5;
  localparam int ST_OVR_BASE = 8;
  localparam int ST_DATA_READY_FLAG_BIT = 16;
  localparam int ST_GOVR_BIT = 17;
  localparam int LAST_CH_POS = 12;
  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DATA_READY_FLAG = 0;
  localparam int IRQ_GOVR = 1;
  localparam int IRQ_OVR = 2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic              done;
    logic [2:0]        ch;
    logic [DATA_W-1:0] data;
  } acsf_conv_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } acsf_bus_t;
endpackage
`default_nettype wire

/* File: bench/acsf_core_model.sv */
`default_nettype none
module acsf_core_model (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Controller side
  input  wire logic                        start_conv,
  output var  acsf_pkg::acsf_conv_t        conv,
  // Bench trigger
  input  wire logic                        fire,
  input  wire logic [2:0]                  fire_ch,
  input  wire logic [acsf_pkg::DATA_W-1:0] fire_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] junk_q;
  // Idle lines toggle so stale data never looks valid
  always_ff @(posedge clk_sys) begin
    junk_q <= (rst | start_conv) ? 10'h155 : ~junk_q;
  end
  assign conv = fire ? {1'h1, fire_ch, fire_data} : {1'h0, junk_q[2:0], junk_q};
endmodule
`default_nettype wire

/* File: bench/acsf_flags_tb_top.sv */
`default_nettype none
module acsf_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys, rst, fire, start_conv, sleep_active, irq, sc;
  acsf_pkg::acsf_bus_t  bus;
  acsf_pkg::acsf_conv_t conv;
  logic [31:0]          rdata, v;
  logic [7:0]           ch_enable;
  logic [2:0]           c, fire_ch;
  logic [9:0]           d, fire_data;
  int                   n_fail, checks_done, seed, i;

  acsf_flags #(.NUM_CH(8)) i_dut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .conv(conv), .start_conv(start_conv), .ch_enable(ch_enable),
    .sleep_active(sleep_active), .irq(irq));
  acsf_core_model i_core (.clk_sys(clk_sys), .rst(rst), .start_conv(start_conv), .conv(conv),
    .fire(fire), .fire_ch(fire_ch), .fire_data(fire_data));

  function automatic logic [31:0] st(input logic [7:0] e, o, input logic dr, gv);
    return {14'h0, gv, dr, o, e};
  endfunction
  function automatic logic [31:0] lw(input logic [2:0] ch, input logic [9:0] dt);
    return {17'h0, ch, 2'h0, dt};
  endfunction
  task automatic give_verdict();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus slot, optionally with a completion in the same cycle
  task automatic acc(input logic w, r, f, input logic [7:0] a, input logic [31:0] wd);
    bus <= '{a, wd, w, r};
    fire <= f;
    fire_ch <= c;
    fire_data <= d;
    @(posedge clk_sys);
    bus.wr <= 1'h0;
    bus.rd <= 1'h0;
    fire <= 1'h0;
    #1 v = rdata;
    sc = start_conv;
    @(posedge clk_sys);
  endtask
  task automatic fe(input logic [2:0] ch);
    c = ch;
    d = 10'($random(seed));
    acc(0, 0, 1, 8'h0, 32'h0);
  endtask
  task automatic rs(input logic f);
    acc(0, 1, f, acsf_pkg::OFS_STATUS, 32'h0);
  endtask
  task automatic rl(input logic f);
    acc(0, 1, f, acsf_pkg::OFS_LAST, 32'h0);
  endtask
  task automatic rc(input logic [2:0] ch, input logic f);
    acc(0, 1, f, acsf_pkg::OFS_CH_BASE + 8'(4 * ch), 32'h0);
  endtask

  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Whole sequence needs well under 1000 cycles
  initial begin
    #20000;
    n_fail++;
    give_verdict();
  end
  initial begin
    seed = 38;
    rst = 1'h1;
    fire = 1'h0;
    fire_ch = 3'h0;
    fire_data = 10'h0;
    bus = '0;
    c = 3'h0;
    d = 10'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    rs(0);
    chk("status", st(8'h0, 8'h0, 0, 0), v);
    acc(0, 1, 0, 8'hfc, 32'h0);
    chk("unmapped", 32'h0, v);
    acc(1, 0, 0, acsf_pkg::OFS_CH_EN, 32'hff);
    for (i = 0; i < 6; i++) begin
      fe(3'($random(seed)));
      rc(c, 0);
      chk("cdr", {22'h0, d}, v);
      rs(0);
      chk("status", st(8'h0, 8'h0, 1, 0), v);
      rl(0);
      chk("last", lw(c, d), v);
      rs(0);
      chk("status", st(8'h0, 8'h0, 0, 0), v);
    end
    fe(3'h1);
    fe(3'h4);
    c = 3'h6;
    rc(3'h1, 1);
    rs(0);
    chk("status", st(8'h50, 8'h0, 1, 1), v);
    rs(0);
    chk("status", st(8'h50, 8'h0, 1, 0), v);
    c = 3'h2;
    rl(1);
    chk("last", lw(3'h6, fire_data), v);
    fe(3'h3);
    fe(3'h3);
    rc(3'h3, 0);
    rs(1);
    chk("status", st(8'h14, 8'h08, 1, 1), v);
    rs(0);
    chk("status", st(8'h1c, 8'h0, 1, 1), v);
    rs(0);
    chk("status", st(8'h1c, 8'h0, 1, 0), v);
    rl(0);
    acc(1, 0, 0, acsf_pkg::OFS_CH_DIS, 32'h20);
    fe(3'h5);
    rs(0);
    chk("status", st(8'h14, 8'h0, 0, 0), v);
    c = 3'h7;
    d = 10'h3ff;
    acc(1, 0, 1, acsf_pkg::OFS_CH_DIS, 32'h01);
    chk("ch_enable", 32'hde, {24'h0, ch_enable});
    rl(0);
    chk("last", lw(3'h7, 10'h3ff), v);
    // Earlier completions left sticky bits behind; start from a clean status
    acc(1, 0, 0, acsf_pkg::OFS_IRQ_CLR, 32'h7);
    acc(1, 0, 0, acsf_pkg::OFS_IRQ_EN, 32'h1);
    #1 chk("irq", 32'h0, {31'h0, irq});
    fe(3'h7);
    #1 chk("irq", 32'h1, {31'h0, irq});
    acc(0, 1, 0, acsf_pkg::OFS_IRQ_ST, 32'h0);
    chk("irq_st", 32'h1, v);
    acc(1, 0, 0, acsf_pkg::OFS_IRQ_CLR, 32'h1);
    #1 chk("irq", 32'h0, {31'h0, irq});
    acc(1, 0, 0, acsf_pkg::OFS_IRQ_EN, 32'h0);
    fe(3'h7);
    #1 chk("irq", 32'h0, {31'h0, irq});
    acc(1, 0, 0, acsf_pkg::OFS_MODE, 32'h20);
    chk("start_conv", 32'h0, {31'h0, sc});
    acc(1, 0, 0, acsf_pkg::OFS_CTRL, 32'h2);
    chk("start_conv", 32'h1, {31'h0, sc});
    chk("sleep", 32'h0, {31'h0, sleep_active});
    fe(3'h7);
    #1 chk("sleep", 32'h1, {31'h0, sleep_active});
    give_verdict();
  end
endmodule
`default_nettype wire
